// [fsc_consts.vh]
// Purpose: shared constants of the front-end serial control block
// Assumes: included by bare name from the control top and the serial receiver
// Notes: definitions only
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH

// ==========================================================
// serial frame
`define FSC_FRAME_BITS 5'h10
`define FSC_ADDR_MSB 15
`define FSC_ADDR_LSB 12
`define FSC_DATA_MSB 11
`define FSC_DATA_LSB 0

// ==========================================================
// register addresses
`define FSC_ADDR_GAIN 4'h0
`define FSC_ADDR_DAC 4'h1
`define FSC_ADDR_CLAMP 4'h2
`define FSC_ADDR_POL 4'h3
`define FSC_ADDR_EXTGAIN 4'h4
`define FSC_ADDR_INIT 4'hF

// ==========================================================
// field positions
`define FSC_POL_DARK_CLAMP 0
`define FSC_POL_BLACK_CLAMP 1
`define FSC_POL_BLANKING 3
`define FSC_POL_SAMPLE 4
`define FSC_POL_PIX_EDGE 5
`define FSC_POL_OE_SENSE 6
`define FSC_POL_STANDBY 7
`define FSC_POL_VSYNC_EDGE 8
`define FSC_EXTGAIN_BIT 7
`define FSC_CODE8_MSB 7
`define FSC_CLAMP_MSB 6

// ==========================================================
// reset values and fixed codes
`define FSC_GAIN_RST 8'h00
`define FSC_DAC_RST 8'h00
`define FSC_CLAMP_RST 7'h00
`define FSC_POL_RST 12'h204
`define FSC_EXTGAIN_RST 1'h0
`define FSC_INIT_CODE 12'h100

`endif

// [fsc_ctrl_asserts.sv]
// Purpose: concurrent checks on the serial control bank ports
// Assumes: pins change away from the rising clock edge
// Notes: pin-driven outputs may move only on a pin change or a pixel commit
`timescale 1ns/1ps
module fsc_ctrl_asserts (
  input wire mclk_in,             // clock
  input wire rst_n_in,            // reset
  input wire vsync_in,            // pin
  input wire dark_clamp_pulse_in, // pin
  input wire standby_pin_in,      // pin
  input wire adc_oe_pin_in,       // pin
  input wire [7:0] gain_code_out, // gain
  input wire [6:0] clamp_ref_out, // clamp
  input wire dark_clamp_act_out,  // clamp active
  input wire pix_strobe_out,      // pixel commit
  input wire vsync_strobe_out,    // vsync edge
  input wire standby_out,         // standby
  input wire adc_out_en_n_out,    // output enable
  input wire init_pulse_out,      // init
  input wire test_mode_out        // test mode
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // assertions
  gain_commit_a: assert property ($changed(gain_code_out) |->
    pix_strobe_out || $past(pix_strobe_out)) else $error("gain moved off a commit");
  clamp_commit_a: assert property ($changed(clamp_ref_out) |->
    pix_strobe_out || $past(pix_strobe_out)) else $error("clamp moved off a commit");
  pix_single_a: assert property (pix_strobe_out |=> !pix_strobe_out)
    else $error("pixel strobe too long");
  vsync_cause_a: assert property (vsync_strobe_out |->
    $past(vsync_in) != $past(vsync_in, 7) ##1 !vsync_strobe_out [*3])
    else $error("vsync strobe without an edge");
  init_single_a: assert property (init_pulse_out |=> !init_pulse_out)
    else $error("init pulse too long");
  test_clear_a: assert property ($fell(test_mode_out) |->
    (init_pulse_out || $past(init_pulse_out) || $past(init_pulse_out, 2)) or
    ##[1:3] init_pulse_out) else $error("test mode left without init");
  clamp_act_a: assert property ($changed(dark_clamp_act_out) && $past(rst_n_in, 7) |->
    pix_strobe_out || $past(pix_strobe_out) ||
    $past(dark_clamp_pulse_in) != $past(dark_clamp_pulse_in, 7)) else $error("clamp act moved");
  standby_cause_a: assert property ($changed(standby_out) && $past(rst_n_in, 7) |->
    pix_strobe_out || $past(pix_strobe_out) ||
    $past(standby_pin_in) != $past(standby_pin_in, 7)) else $error("standby moved");
  oe_cause_a: assert property ($changed(adc_out_en_n_out) && $past(rst_n_in, 7) |->
    pix_strobe_out || $past(pix_strobe_out) ||
    $past(adc_oe_pin_in) != $past(adc_oe_pin_in, 7)) else $error("output enable moved");
  init_c: cover property (init_pulse_out);
  standby_c: cover property ($rose(standby_out));
  vsync_c: cover property (vsync_strobe_out);
endmodule
bind fsc_ctrl_top fsc_ctrl_asserts i_fsc_ctrl_asserts (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .vsync_in(vsync_in), .dark_clamp_pulse_in(dark_clamp_pulse_in),
  .standby_pin_in(standby_pin_in), .adc_oe_pin_in(adc_oe_pin_in),
  .gain_code_out(gain_code_out), .clamp_ref_out(clamp_ref_out),
  .dark_clamp_act_out(dark_clamp_act_out), .pix_strobe_out(pix_strobe_out),
  .vsync_strobe_out(vsync_strobe_out), .standby_out(standby_out),
  .adc_out_en_n_out(adc_out_en_n_out), .init_pulse_out(init_pulse_out),
  .test_mode_out(test_mode_out));

// [fsc_ctrl_top.v]
// Purpose: control register bank of a ccd analog front end, loaded over 3 wires
// Assumes: all pins asynchronous to mclk_in; link clock sampled, not used as a clock
//   serial link clock at most a quarter of mclk_in
// Notes: serial writes land in shadow registers, datapath copies follow pixel edges
//   no read-back path, so the controller keeps its own copy of every setting
//   pin-derived outputs lag their pins by four mclk_in cycles
// How it works
// - address 0 loads data bits 7..0 as the amplifier gain code.
// - address 1 loads data bits 7..0 as the auxiliary dac code.
// - address 2 loads data bits 6..0 as the clamp reference, 0 to 127.
// - polarity bits 4,0,1,3 choose high or low activity of sample, clamp, blank pulses.
// - polarity bit 5 picks rising (1) or falling (0) pixel clock edge.
// - polarity bit 8 picks vertical sync rising (0) or falling (1) edge.
// - extended gain bit 7 resets to zero; one widens gain range to 36 dB.
// - init address with data exactly bit 8 set starts an initialization.
// - writes to unassigned addresses select test modes.
// - standby when polarity bit 7 equals standby pin; only the flag is made, holding outputs is left to the datapath.
// - bit 6 one drives outputs while enable pin low; zero inverts pin sense.
`timescale 1ns/1ps
`include "fsc_consts.vh"
module fsc_ctrl_top (
  input wire mclk_in,                    // system clock, 100 MHz
  input wire rst_n_in,                   // synchronous reset, active low
  input wire sclk_in,                    // serial clock pin
  input wire sdata_in,                   // serial data pin
  input wire sen_n_in,                   // serial frame enable, active low
  input wire pix_clk_in,                 // pixel clock pin
  input wire vsync_in,                   // vertical sync pin
  input wire reference_sample_pulse_in,  // reference sample pulse pin
  input wire data_sample_pulse_in,       // data sample pulse pin
  input wire dark_clamp_pulse_in,        // dark clamp pulse pin
  input wire black_clamp_pulse_in,       // black clamp pulse pin
  input wire blanking_pulse_in,          // blanking pulse pin
  input wire standby_pin_in,             // standby pin
  input wire adc_oe_pin_in,              // adc output enable pin, low active when sense=1
  output reg [7:0] gain_code_out,        // amplifier gain code
  output reg ext_gain_out,               // extended gain range enable
  output reg [7:0] aux_dac_output_out,   // auxiliary dac code
  output reg [6:0] clamp_ref_out,        // clamp reference code
  output reg reference_sample_act_out,   // reference sample, active high
  output reg data_sample_act_out,        // data sample, active high
  output reg dark_clamp_act_out,         // dark clamp, active high
  output reg black_clamp_act_out,        // black clamp, active high
  output reg blanking_act_out,           // blanking, active high
  output reg pix_strobe_out,             // pulse on selected pixel clock edge
  output reg vsync_strobe_out,           // pulse on selected vsync edge
  output reg standby_out,                // analog chain in standby, hold outputs
  output reg adc_out_en_n_out,           // adc outputs driven when low
  output reg init_pulse_out,             // one-cycle initialization pulse
  output reg test_mode_out,              // a test mode address was written
  output reg [3:0] test_sel_out          // last test mode address
);

  // ==========================================================
  // serial word reception
  wire word_valid;
  wire [15:0] word;
  wire [3:0] waddr;
  wire [11:0] wdata;
  wire [7:0] code8;
  wire [6:0] code7;
  wire ext_bit;

  fsc_serial_rx u_rx (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .sdata_in(sdata_in),
    .sen_n_in(sen_n_in),
    .word_valid_out(word_valid),
    .word_out(word)
  );

  assign waddr = word[`FSC_ADDR_MSB:`FSC_ADDR_LSB];
  assign wdata = word[`FSC_DATA_MSB:`FSC_DATA_LSB];
  assign code8 = wdata[`FSC_CODE8_MSB:0];
  assign code7 = wdata[`FSC_CLAMP_MSB:0];
  assign ext_bit = wdata[`FSC_EXTGAIN_BIT];

  // ==========================================================
  // pin synchronisers, one loop over the pulse and level pins
  localparam NPIN = 9;
  localparam P_REF = 0;
  localparam P_DAT = 1;
  localparam P_DARK = 2;
  localparam P_BLACK = 3;
  localparam P_BLANK = 4;
  localparam P_STBY = 5;
  localparam P_OE = 6;
  localparam P_PIX = 7;
  localparam P_VS = 8;
  localparam NACT = 5;

  wire [NPIN-1:0] pins;
  wire [NPIN-1:0] lvl;
  wire [NPIN-1:0] rise;
  wire [NPIN-1:0] fall;

  assign pins[P_REF] = reference_sample_pulse_in;
  assign pins[P_DAT] = data_sample_pulse_in;
  assign pins[P_DARK] = dark_clamp_pulse_in;
  assign pins[P_BLACK] = black_clamp_pulse_in;
  assign pins[P_BLANK] = blanking_pulse_in;
  assign pins[P_STBY] = standby_pin_in;
  assign pins[P_OE] = adc_oe_pin_in;
  assign pins[P_PIX] = pix_clk_in;
  assign pins[P_VS] = vsync_in;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      fsc_edge_sync u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .pin_in(pins[gi]),
        .level_out(lvl[gi]),
        .rise_out(rise[gi]),
        .fall_out(fall[gi])
      );
    end
  endgenerate

  // ==========================================================
  // shadow registers, written from the serial link
  reg [7:0] gain_sh_q;
  reg [7:0] dac_sh_q;
  reg [6:0] clamp_sh_q;
  reg [11:0] pol_sh_q;
  reg ext_sh_q;
  reg init_req_q;

  wire is_init_word;
  wire is_assigned;

  assign is_init_word = (wdata == `FSC_INIT_CODE);
  assign is_assigned = (waddr == `FSC_ADDR_GAIN) || (waddr == `FSC_ADDR_DAC) ||
                       (waddr == `FSC_ADDR_CLAMP) || (waddr == `FSC_ADDR_POL) ||
                       (waddr == `FSC_ADDR_EXTGAIN) || (waddr == `FSC_ADDR_INIT);

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      gain_sh_q <= `FSC_GAIN_RST;
      dac_sh_q <= `FSC_DAC_RST;
      clamp_sh_q <= `FSC_CLAMP_RST;
      pol_sh_q <= `FSC_POL_RST;
      ext_sh_q <= `FSC_EXTGAIN_RST;
      init_req_q <= 1'b0;
    end else begin
      init_req_q <= 1'b0;
      if (word_valid) begin
        case (waddr)
          `FSC_ADDR_GAIN: begin
            gain_sh_q <= code8;
          end
          `FSC_ADDR_DAC: begin
            dac_sh_q <= code8;
          end
          `FSC_ADDR_CLAMP: begin
            clamp_sh_q <= code7;
          end
          `FSC_ADDR_POL: begin
            // bits 2 and 9 stored as written; the controller keeps them at one
            pol_sh_q <= wdata;
          end
          `FSC_ADDR_EXTGAIN: begin
            ext_sh_q <= ext_bit;
          end
          `FSC_ADDR_INIT: begin
            // a malformed init word is ignored rather than half-applied
            if (is_init_word) begin
              gain_sh_q <= `FSC_GAIN_RST;
              dac_sh_q <= `FSC_DAC_RST;
              clamp_sh_q <= `FSC_CLAMP_RST;
              pol_sh_q <= `FSC_POL_RST;
              ext_sh_q <= `FSC_EXTGAIN_RST;
              init_req_q <= 1'b1;
            end
          end
          default: begin
            // unassigned addresses only feed the test mode flag below
          end
        endcase
      end
    end
  end

  // ==========================================================
  // test mode flag, sticky until an init word or reset
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      test_mode_out <= 1'b0;
      test_sel_out <= 4'h0;
    end else if (word_valid && !is_assigned) begin
      test_mode_out <= 1'b1;
      test_sel_out <= waddr;
    end else if (word_valid && waddr == `FSC_ADDR_INIT && is_init_word) begin
      // a malformed init word leaves the flag set
      test_mode_out <= 1'b0;
    end
  end

  // ==========================================================
  // datapath copies, loaded on the selected pixel clock edge
  reg [11:0] pol_q;
  wire pix_edge;

  // edge choice uses the live copy so one setting governs a whole sample
  assign pix_edge = pol_q[`FSC_POL_PIX_EDGE] ? rise[P_PIX] : fall[P_PIX];

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      gain_code_out <= `FSC_GAIN_RST;
      aux_dac_output_out <= `FSC_DAC_RST;
      clamp_ref_out <= `FSC_CLAMP_RST;
      pol_q <= `FSC_POL_RST;
      ext_gain_out <= `FSC_EXTGAIN_RST;
      pix_strobe_out <= 1'b0;
    end else begin
      pix_strobe_out <= pix_edge;
      if (pix_edge) begin
        gain_code_out <= gain_sh_q;
        aux_dac_output_out <= dac_sh_q;
        clamp_ref_out <= clamp_sh_q;
        pol_q <= pol_sh_q;
        ext_gain_out <= ext_sh_q;
      end
    end
  end

  // ==========================================================
  // pulse pins normalised to active high; the two sample pins share polarity bit 4
  wire [NACT-1:0] act_pol;
  wire [NACT-1:0] act_d;

  assign act_pol[P_REF] = pol_q[`FSC_POL_SAMPLE];
  assign act_pol[P_DAT] = pol_q[`FSC_POL_SAMPLE];
  assign act_pol[P_DARK] = pol_q[`FSC_POL_DARK_CLAMP];
  assign act_pol[P_BLACK] = pol_q[`FSC_POL_BLACK_CLAMP];
  assign act_pol[P_BLANK] = pol_q[`FSC_POL_BLANKING];

  // a bit of one means the pin is active high, so xor with its inverse
  generate
    for (gi = 0; gi < NACT; gi = gi + 1) begin : g_act
      assign act_d[gi] = lvl[gi] ^ ~act_pol[gi];
    end
  endgenerate

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reference_sample_act_out <= 1'b0;
      data_sample_act_out <= 1'b0;
      dark_clamp_act_out <= 1'b0;
      black_clamp_act_out <= 1'b0;
      blanking_act_out <= 1'b0;
    end else begin
      reference_sample_act_out <= act_d[P_REF];
      data_sample_act_out <= act_d[P_DAT];
      dark_clamp_act_out <= act_d[P_DARK];
      black_clamp_act_out <= act_d[P_BLACK];
      blanking_act_out <= act_d[P_BLANK];
    end
  end

  // ==========================================================
  // vertical sync edge and initialization pulse
  wire vsync_edge;

  // both edges are detected; the polarity bit only picks one
  assign vsync_edge = pol_q[`FSC_POL_VSYNC_EDGE] ? fall[P_VS] : rise[P_VS];

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      vsync_strobe_out <= 1'b0;
      init_pulse_out <= 1'b0;
    end else begin
      vsync_strobe_out <= vsync_edge;
      init_pulse_out <= init_req_q;
    end
  end

  // ==========================================================
  // standby and adc output enable
  wire standby_d;
  wire adc_en_n_d;

  // only the flag is made here; holding the adc data is the datapath's job
  assign standby_d = (pol_q[`FSC_POL_STANDBY] == lvl[P_STBY]);
  // sense one: drive while pin low; sense zero: drive while pin high
  assign adc_en_n_d = ~(pol_q[`FSC_POL_OE_SENSE] ^ lvl[P_OE]);

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      standby_out <= 1'b0;
      adc_out_en_n_out <= 1'b1;
    end else begin
      standby_out <= standby_d;
      adc_out_en_n_out <= adc_en_n_d;
    end
  end

endmodule

// [fsc_edge_sync.v]
// Purpose: two-stage synchroniser with edge detection for one pin
// Assumes: pin is asynchronous to mclk_in
// Notes: outputs lag the pin by three clock edges
`timescale 1ns/1ps
module fsc_edge_sync (
  input wire mclk_in,   // system clock
  input wire rst_n_in,  // synchronous reset, active low
  input wire pin_in,    // asynchronous pin
  output reg level_out, // synchronised level
  output reg rise_out,  // one-cycle pulse on rising edge
  output reg fall_out   // one-cycle pulse on falling edge
);

  reg meta_q;
  reg sync_q;
  reg [2:0] fill_q;

  // ==========================================================
  // synchroniser: meta_q feeds sync_q only
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      fill_q <= 3'h0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      level_out <= sync_q;
      fill_q <= {fill_q[1:0], 1'b1};
      // no edge until level_out holds a real sample: a pin idling high
      // would otherwise give a false rise right after reset
      rise_out <= fill_q[2] & sync_q & ~level_out;
      fall_out <= fill_q[2] & ~sync_q & level_out;
    end
  end

endmodule

// [fsc_serial_host.sv]
// Purpose: camera controller model writing words over the 3-wire link
// Assumes: link clock made from system clock falling edges, 80 ns period
// Notes: link clock rests low between frames; data line flips when released
`timescale 1ns/1ps
module fsc_serial_host (
  input wire mclk_in,  // system clock
  output reg sclk_out, // link clock
  output reg sdata_out, // link data
  output reg sen_n_out // frame enable, active low
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    sen_n_out = 1'b1;
  end
  // ==========
  // one frame, msb first; nb below 16 makes a short frame
  task send(input [15:0] w, input integer nb);
    integer i;
    begin
      repeat (8) @(negedge mclk_in);
      sen_n_out = 1'b0;
      for (i = 0; i < nb; i = i + 1) begin
        sdata_out = w[15 - i];
        repeat (4) @(negedge mclk_in);
        sclk_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        sclk_out = 1'b0;
      end
      repeat (4) @(negedge mclk_in);
      sen_n_out = 1'b1;
      sdata_out = ~sdata_out; // stale level must not look valid
    end
  endtask
endmodule

// [fsc_serial_rx.v]
// Purpose: 3-wire serial receiver, 4 address bits then 12 data bits
// Assumes: sclk well below mclk/4; data sampled on sclk rising edge, msb first
// Notes: a word is released only when the enable closes after exactly 16 bits
`timescale 1ns/1ps
`include "fsc_consts.vh"
module fsc_serial_rx (
  input wire mclk_in,       // system clock
  input wire rst_n_in,      // synchronous reset, active low
  input wire sclk_in,       // serial clock pin
  input wire sdata_in,      // serial data pin
  input wire sen_n_in,      // frame enable pin, active low
  output reg word_valid_out, // one-cycle pulse, word complete
  output reg [15:0] word_out // address and data of last word
);

  wire sclk_rise;
  wire sen_n_lvl;
  wire sen_n_rise;
  wire sen_n_fall;
  wire sdata_lvl;
  reg [15:0] shift_q;
  reg [4:0] count_q;
  reg over_q;

  // ==========================================================
  // pin synchronisers
  fsc_edge_sync u_sclk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(sclk_in),
    .level_out(), .rise_out(sclk_rise), .fall_out()
  );
  fsc_edge_sync u_sen (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(sen_n_in),
    .level_out(sen_n_lvl), .rise_out(sen_n_rise), .fall_out(sen_n_fall)
  );
  fsc_edge_sync u_sdata (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(sdata_in),
    .level_out(sdata_lvl), .rise_out(), .fall_out()
  );

  // ==========================================================
  // shifter: a short or long frame is dropped whole
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      over_q <= 1'b0;
      word_valid_out <= 1'b0;
      word_out <= 16'h0000;
    end else begin
      word_valid_out <= 1'b0;
      if (sen_n_fall) begin
        count_q <= 5'h00;
        over_q <= 1'b0;
      end else if (!sen_n_lvl && sclk_rise) begin
        shift_q <= {shift_q[14:0], sdata_lvl};
        if (count_q == `FSC_FRAME_BITS) begin
          over_q <= 1'b1;
        end else begin
          count_q <= count_q + 5'h01;
        end
      end else if (sen_n_rise) begin
        if (count_q == `FSC_FRAME_BITS && !over_q) begin
          word_valid_out <= 1'b1;
          word_out <= shift_q;
        end
        count_q <= 5'h00;
      end
    end
  end

endmodule

// [tb_top.sv]
// Purpose: self-checking bench of the serial control bank
// Assumes: inputs change on falling system clock edges
// Notes: pixel clock can be stopped to count strobes per single edge
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  reg mclk_in, rst_n_in, pix_clk, vsync, pp, stby, oe, pix_run;
  wire sclk, sdata, sen_n, ext_gain_out, pix_strobe_out, vsync_strobe_out, standby_out;
  wire reference_sample_act_out, data_sample_act_out, dark_clamp_act_out;
  wire black_clamp_act_out, blanking_act_out, adc_out_en_n_out, init_pulse_out, test_mode_out;
  wire [7:0] gain_code_out, aux_dac_output_out;
  wire [6:0] clamp_ref_out;
  wire [3:0] test_sel_out;
  reg [7:0] e_gain, e_dac;
  reg [6:0] e_clamp;
  reg [11:0] e_pol;
  reg [3:0] e_sel;
  reg e_ext, e_test;
  integer err_total = 0, num_checks = 0;
  fsc_serial_host i_fsc_serial_host (.mclk_in(mclk_in), .sclk_out(sclk), .sdata_out(sdata),
    .sen_n_out(sen_n));
  fsc_ctrl_top i_fsc_ctrl_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .sdata_in(sdata), .sen_n_in(sen_n), .pix_clk_in(pix_clk), .vsync_in(vsync),
    .reference_sample_pulse_in(pp), .data_sample_pulse_in(pp), .dark_clamp_pulse_in(pp),
    .black_clamp_pulse_in(pp), .blanking_pulse_in(pp), .standby_pin_in(stby),
    .adc_oe_pin_in(oe), .gain_code_out(gain_code_out), .ext_gain_out(ext_gain_out),
    .aux_dac_output_out(aux_dac_output_out), .clamp_ref_out(clamp_ref_out),
    .reference_sample_act_out(reference_sample_act_out), .blanking_act_out(blanking_act_out),
    .data_sample_act_out(data_sample_act_out), .dark_clamp_act_out(dark_clamp_act_out),
    .black_clamp_act_out(black_clamp_act_out), .pix_strobe_out(pix_strobe_out),
    .vsync_strobe_out(vsync_strobe_out), .standby_out(standby_out),
    .adc_out_en_n_out(adc_out_en_n_out), .init_pulse_out(init_pulse_out),
    .test_mode_out(test_mode_out), .test_sel_out(test_sel_out));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always begin
    repeat (4) @(negedge mclk_in);
    if (pix_run) pix_clk = ~pix_clk;
  end
  // ==========
  // expectations and tasks
  task set_rst;
    begin
      e_gain = 8'h00;
      e_dac = 8'h00;
      e_clamp = 7'h00;
      e_pol = 12'h204;
      e_ext = 1'b0;
      e_test = 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check_all;
    begin
      `CHK(gain_code_out, e_gain)
      `CHK(aux_dac_output_out, e_dac)
      `CHK(clamp_ref_out, e_clamp)
      `CHK(ext_gain_out, e_ext)
      `CHK(reference_sample_act_out, ~(pp ^ e_pol[4]))
      `CHK(data_sample_act_out, ~(pp ^ e_pol[4]))
      `CHK(dark_clamp_act_out, ~(pp ^ e_pol[0]))
      `CHK(black_clamp_act_out, ~(pp ^ e_pol[1]))
      `CHK(blanking_act_out, ~(pp ^ e_pol[3]))
      `CHK(standby_out, e_pol[7] == stby)
      `CHK(adc_out_en_n_out, ~(e_pol[6] ^ oe))
      `CHK(test_mode_out, e_test)
      if (e_test) `CHK(test_sel_out, e_sel)
    end
  endtask
  // write, then wait for the pixel commit that publishes it
  task wr(input [3:0] a, input [11:0] d, input integer nb);
    integer i, np;
    begin
      i_fsc_serial_host.send({a, d}, nb);
      np = 0;
      for (i = 0; i < 60; i = i + 1) begin
        @(negedge mclk_in);
        if (init_pulse_out === 1'b1) np = np + 1;
        if (i >= 8 && pix_strobe_out === 1'b1) break;
      end
      if (i == 60) begin
        err_total++;
        $display("MISMATCH t=%0t no pixel commit", $time);
        tally_and_finish;
      end
      `CHK(np, (nb == 16 && a == 4'hF && d == 12'h100) ? 1 : 0)
      if (nb == 16) case (a)
        4'h0: e_gain = d[7:0];
        4'h1: e_dac = d[7:0];
        4'h2: e_clamp = d[6:0];
        4'h3: e_pol = d;
        4'h4: e_ext = d[7];
        4'hF: if (d == 12'h100) set_rst;
        default: begin
          e_test = 1'b1;
          e_sel = a;
        end
      endcase
      // pin-derived outputs take the new polarity one cycle after the commit
      repeat (2) @(negedge mclk_in);
      check_all;
    end
  endtask
  task strobe_cnt(output integer p, output integer v);
    integer k;
    begin
      p = 0;
      v = 0;
      for (k = 0; k < 12; k = k + 1) begin
        @(negedge mclk_in);
        if (pix_strobe_out === 1'b1) p = p + 1;
        if (vsync_strobe_out === 1'b1) v = v + 1;
      end
    end
  endtask
  task pol_case(input [11:0] p);
    integer np, nv;
    begin
      wr(4'h3, p, 16);
      @(posedge mclk_in) pix_run = 1'b0;
      repeat (8) @(negedge mclk_in);
      pix_clk = 1'b0;
      vsync = 1'b0;
      repeat (10) @(negedge mclk_in);
      pix_clk = 1'b1;
      vsync = 1'b1;
      strobe_cnt(np, nv);
      `CHK(np, p[5] ? 1 : 0)
      `CHK(nv, p[8] ? 0 : 1)
      pix_clk = 1'b0;
      vsync = 1'b0;
      strobe_cnt(np, nv);
      `CHK(np, p[5] ? 0 : 1)
      `CHK(nv, p[8] ? 1 : 0)
      @(posedge mclk_in) pix_run = 1'b1;
      repeat (2) begin
        @(negedge mclk_in);
        pp = ~pp;
        stby = ~stby;
        oe = ~oe;
        repeat (8) @(negedge mclk_in);
        check_all;
      end
    end
  endtask
  // ==========
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    pix_clk = 1'b0;
    vsync = 1'b0;
    pp = 1'b1;
    stby = 1'b1;
    oe = 1'b0;
    pix_run = 1'b1;
    set_rst;
    repeat (10) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    check_all;
    wr(4'h0, 12'hFA5, 16);
    wr(4'h1, 12'h13C, 16);
    wr(4'h2, 12'hFFF, 16);
    wr(4'h4, 12'h080, 16);
    wr(4'h4, 12'hF7F, 16);
    wr(4'h0, 12'h3C7, 15);
    pol_case(12'h3B6);
    pol_case(12'h24D);
    wr(4'h5, 12'h000, 16);
    wr(4'hE, 12'h000, 16);
    wr(4'hF, 12'h101, 16);
    wr(4'hF, 12'h100, 16);
    tally_and_finish;
  end
endmodule
